// >>> core/sphc_pkg.sv
// package: constants and types for the static power hold controller
package sphc_pkg;

  // -----------------------------------------------------------------
  // clock and timing
  // -----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 10000;
  localparam int unsigned ENTRY_DELAY_NS = 1000;
  localparam int unsigned EXIT_DELAY_NS = 1000;
  localparam int unsigned ENTRY_CYCLES = (ENTRY_DELAY_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned EXIT_LIMIT_CYCLES = (EXIT_DELAY_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned FILTER_CYCLES = 4;
  localparam int unsigned CNT_W = 8;

  // -----------------------------------------------------------------
  // pads and registers
  // -----------------------------------------------------------------
  localparam int unsigned NUM_PADS = 8;
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 4'h0;
  localparam logic [ADDR_W-1:0] PULL_EN_OFFSET = 4'h4;
  localparam logic [ADDR_W-1:0] PULL_UP_OFFSET = 4'h8;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'hc;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] PULL_RESET = 32'h0000_0000;
  localparam int unsigned CTRL_TYPE2_BIT = 0;

  typedef enum logic [1:0] {
    SPHC_RUN = 2'b00,
    SPHC_ENTERING = 2'b01,
    SPHC_HOLD = 2'b10
  } sphc_state_t;

  typedef struct packed {
    logic [31:0] wdata;
    logic [ADDR_W-1:0] addr;
    logic wr;
    logic rd;
  } sphc_bus_req_t;

  typedef struct packed {
    logic [NUM_PADS-1:0] out;
    logic [NUM_PADS-1:0] oe;
    logic [NUM_PADS-1:0] pull_en;
    logic [NUM_PADS-1:0] pull_up;
  } sphc_pad_t;

endpackage

// >>> core/sphc_sync_filter.sv
// synchroniser plus glitch filter for the hold request pin
`timescale 1ns/1ps
`default_nettype none
module sphc_sync_filter
  import sphc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic level_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic [CNT_W-1:0] cnt_q;

  // -----------------------------------------------------------------
  // three-stage synchroniser
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // -----------------------------------------------------------------
  // filter: level must hold steady before it is accepted
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      level_o <= 1'b1;
    end else if (s2_q != s3_q || s3_q == level_o) begin
      cnt_q <= '0; // [R15]
    end else if (cnt_q == CNT_W'(FILTER_CYCLES - 1)) begin
      cnt_q <= '0;
      level_o <= s3_q; // [R16]
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end
endmodule
`default_nettype wire

// >>> core/sphc_top.sv
// static power hold controller: entry/exit sequencing and pad/core forcing
// What this block does, and what its user must do
// [R01] type 1: enter hold 1 us after pin low
// [R02] pin high returns device to normal operation
// [R03] type 1: pin level alone decides hold
// [R04] type 2: enter only if pin low and permit
// [R05] permit gates entry only, nothing else
// [R06] user drops permit after type 2 exit
// [R07] pin active low, permit active high
// [R08] unpulled pads tristate during hold
// [R09] pulled pads keep weak pull in hold
// [R10] core sees high from inputs during hold
// [R11] no weak pull on hold pin
// [R12] hold stops embedded clock synthesizer
// [R13] exit completes within 1 us of pin high
// [R14] user keeps permit high until entry done
// [R15] hold pin glitch filtered
// [R16] entry delay counted after synchroniser
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module sphc_top
  import sphc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic hold_request_pin_n_i,
  input wire logic hold_permit_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic [NUM_PADS-1:0] core_out_i,
  input wire logic [NUM_PADS-1:0] core_oe_i,
  input wire logic [NUM_PADS-1:0] pad_in_i,
  output logic [NUM_PADS-1:0] pad_out_o,
  output logic [NUM_PADS-1:0] pad_oe_o,
  output logic [NUM_PADS-1:0] pad_pull_en_o,
  output logic [NUM_PADS-1:0] pad_pull_up_o,
  output logic [NUM_PADS-1:0] core_in_o,
  output logic synth_power_down_o,
  output logic hold_active_o
);
  sphc_state_t state_q;
  logic pin_n_filt;
  logic type2_q;
  logic [NUM_PADS-1:0] pull_en_q;
  logic [NUM_PADS-1:0] pull_up_q;
  logic [CNT_W-1:0] entry_cnt_q;
  logic permit_q;
  logic entry_cond;
  sphc_pad_t pad_d;
  sphc_bus_req_t req;
  logic [NUM_PADS-1:0] core_in_d;

  assign req = '{wdata: reg_wdata_i, addr: reg_addr_i, wr: reg_wr_i, rd: reg_rd_i};

  // -----------------------------------------------------------------
  // decode helpers
  // -----------------------------------------------------------------
  function automatic logic is_hold(input sphc_state_t s);
    return s == SPHC_HOLD;
  endfunction

  // -----------------------------------------------------------------
  // pin input buffer
  // -----------------------------------------------------------------
  // slow filter trades a few cycles of latency for immunity to pin noise
  sphc_sync_filter u_hold_pin_input_buffer (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .pin_i(hold_request_pin_n_i),
    .level_o(pin_n_filt)
  );

  // permit comes from fabric logic on this clock: no synchroniser
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      permit_q <= 1'b0;
    end else begin
      permit_q <= hold_permit_i;
    end
  end

  // -----------------------------------------------------------------
  // entry condition
  // -----------------------------------------------------------------
  // type 1 never looks at permit
  always_comb begin
    if (type2_q) begin
      entry_cond = !pin_n_filt && permit_q; // [R04] [R07]
    end else begin
      entry_cond = !pin_n_filt; // [R03] [R07]
    end
  end

  // -----------------------------------------------------------------
  // hold sequencer
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_q <= SPHC_RUN;
      entry_cnt_q <= '0;
    end else begin
      case (state_q)
        SPHC_RUN: begin
          // every attempt counts from zero, an aborted one leaves nothing behind
          entry_cnt_q <= '0;
          if (entry_cond) begin
            state_q <= SPHC_ENTERING;
          end
        end
        SPHC_ENTERING: begin
          // dropping the entry condition (pin, or permit in type 2) aborts entry; permit matters only in SPHC_RUN and here
          if (!entry_cond) begin
            state_q <= SPHC_RUN; // [R05] [R14]
          end else if (entry_cnt_q == CNT_W'(ENTRY_CYCLES - 1)) begin
            state_q <= SPHC_HOLD; // [R01]
          end else begin
            entry_cnt_q <= entry_cnt_q + CNT_W'(1);
          end
        end
        SPHC_HOLD: begin
          // exit on pin only, whatever permit does; filter latency is well under 1 us
          if (pin_n_filt) begin
            state_q <= SPHC_RUN; // [R02] [R13]
          end
        end
        default: begin
          state_q <= SPHC_RUN;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // pad output and enable forcing
  // -----------------------------------------------------------------
  always_comb begin
    pad_d.pull_en = pull_en_q;
    pad_d.pull_up = pull_up_q;
    if (is_hold(state_q)) begin
      // out parked low as well, so only oe decides the pad in hold
      pad_d.out = '0;
      pad_d.oe = '0; // [R08] [R09]
    end else begin
      pad_d.out = core_out_i;
      pad_d.oe = core_oe_i;
    end
  end

  // -----------------------------------------------------------------
  // core-input forcing, one pad at a time
  // -----------------------------------------------------------------
  for (genvar i = 0; i < NUM_PADS; i++) begin : g_core_in
    assign core_in_d[i] = is_hold(state_q) | pad_in_i[i]; // [R10]
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pad_out_o <= '0;
      pad_oe_o <= '0;
      pad_pull_en_o <= '0;
      pad_pull_up_o <= '0;
      core_in_o <= '1;
    end else begin
      pad_out_o <= pad_d.out;
      pad_oe_o <= pad_d.oe;
      pad_pull_en_o <= pad_d.pull_en; // [R09]
      pad_pull_up_o <= pad_d.pull_up;
      core_in_o <= core_in_d; // [R10]
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      synth_power_down_o <= 1'b0;
      hold_active_o <= 1'b0;
    end else begin
      // synthesizer relock after exit is left to the user logic
      synth_power_down_o <= is_hold(state_q); // [R12]
      hold_active_o <= is_hold(state_q);
    end
  end

  // -----------------------------------------------------------------
  // register port
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      type2_q <= CTRL_RESET[CTRL_TYPE2_BIT];
      pull_en_q <= PULL_RESET[NUM_PADS-1:0];
      pull_up_q <= PULL_RESET[NUM_PADS-1:0];
    end else if (req.wr) begin
      // unmapped writes are dropped; the port has no error response
      case (req.addr)
        CTRL_OFFSET: type2_q <= req.wdata[CTRL_TYPE2_BIT];
        PULL_EN_OFFSET: pull_en_q <= req.wdata[NUM_PADS-1:0];
        PULL_UP_OFFSET: pull_up_q <= req.wdata[NUM_PADS-1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
    end else if (req.rd) begin
      case (req.addr)
        CTRL_OFFSET: reg_rdata_o <= {31'h0, type2_q};
        PULL_EN_OFFSET: reg_rdata_o <= {24'h0, pull_en_q};
        PULL_UP_OFFSET: reg_rdata_o <= {24'h0, pull_up_q};
        STATUS_OFFSET: reg_rdata_o <= {28'h0, permit_q, pin_n_filt, state_q};
        default: reg_rdata_o <= '0;
      endcase
    end else begin
      // data stands one cycle only, so a late sampler sees zero
      reg_rdata_o <= '0;
    end
  end
endmodule
`default_nettype wire

// >>> tb/sphc_top_chk.sv
// assertion checker for the static power hold controller
`timescale 1ns/1ps
`default_nettype none
module sphc_top_chk
  import sphc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic hold_request_pin_n_i,
  input wire logic hold_permit_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic [NUM_PADS-1:0] core_out_i,
  input wire logic [NUM_PADS-1:0] core_oe_i,
  input wire logic [NUM_PADS-1:0] pad_in_i,
  input wire logic [NUM_PADS-1:0] pad_out_o,
  input wire logic [NUM_PADS-1:0] pad_oe_o,
  input wire logic [NUM_PADS-1:0] pad_pull_en_o,
  input wire logic [NUM_PADS-1:0] pad_pull_up_o,
  input wire logic [NUM_PADS-1:0] core_in_o,
  input wire logic synth_power_down_o,
  input wire logic hold_active_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic [7:0] low_q;
  logic [7:0] both_q;
  // saturating run lengths of pin low, and of pin low with permit high
  always_ff @(posedge clk_sys_i) begin
    low_q <= hold_request_pin_n_i ? 8'h00 : low_q + {7'h0, low_q != 8'hff};
    both_q <= (hold_request_pin_n_i | !hold_permit_i) ? 8'h00 : both_q + {7'h0, both_q != 8'hff};
  end
  a_hold_pads_off: assert property (hold_active_o |-> pad_oe_o == '0) else $error("pad driven in hold");
  a_hold_core_high: assert property (hold_active_o |-> core_in_o == '1) else $error("core input low");
  a_synth_stops: assert property (synth_power_down_o == hold_active_o) else $error("synth power");
  a_pull_kept: assert property (hold_active_o && $past(hold_active_o) && !$past(reg_wr_i, 2) |->
    $stable(pad_pull_en_o) && $stable(pad_pull_up_o)) else $error("pull changed in hold");
  a_run_pass: assert property (!hold_active_o && !$past(hold_active_o) && !$past(rst_i) |->
    core_in_o == $past(pad_in_i) && pad_out_o == $past(core_out_i) && pad_oe_o == $past(core_oe_i))
    else $error("run path altered");
  a_entry_not_early: assert property ($rose(hold_active_o) |-> low_q >= 8'h64) else $error("early entry");
  a_entry_in_time: assert property (both_q == 8'h78 |-> hold_active_o) else $error("late entry");
  a_hold_stays: assert property (hold_active_o && low_q >= 8'h0c |=> hold_active_o) else $error("left hold");
  a_exit_bound: assert property ($rose(hold_request_pin_n_i) |-> ##[1:100] !hold_active_o)
    else $error("slow exit");
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0) else $error("stray read data");
endmodule
bind sphc_top sphc_top_chk u_chk (.clk_sys_i, .rst_i, .hold_request_pin_n_i, .hold_permit_i, .reg_wr_i,
  .reg_rd_i, .reg_rdata_o, .core_out_i, .core_oe_i, .pad_in_i, .pad_out_o, .pad_oe_o, .pad_pull_en_o,
  .pad_pull_up_o, .core_in_o, .synth_power_down_o, .hold_active_o);
`default_nettype wire

// >>> tb/sphc_ctl_model.sv
// model of the fabric controller driving the hold pin and permit
`timescale 1ns/1ps
`default_nettype none
module sphc_ctl_model (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic use_permit_i,
  output logic pin_n_o,
  output logic permit_o
);
  // permit tracks the request only while use_permit_i is high: up through entry, down with the pin on exit
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pin_n_o <= 1'b1;
      permit_o <= 1'b0;
    end else begin
      pin_n_o <= !req_i;
      permit_o <= req_i & use_permit_i;
    end
  end
endmodule
`default_nettype wire

// >>> tb/tb.sv
// self-checking testbench for the static power hold controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sphc_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic req = 1'b0;
  logic use_p = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [31:0] wdata = '0;
  logic [31:0] rdata;
  logic pin_n, permit, synth_pd, hold;
  logic [NUM_PADS-1:0] pad_out, pad_oe, pull_en, pull_up, core_in;
  logic [NUM_PADS-1:0] pad_in = '0;
  int err_count = 0;
  int n_checks = 0;
  int n;
  initial forever #5 clk_sys_i = ~clk_sys_i;
  // moving pad inputs, so forcing of the core side in hold is visible
  always @(posedge clk_sys_i) pad_in <= pad_in + 8'h01;
  sphc_ctl_model u_ctl (.clk_sys_i, .rst_i, .req_i(req), .use_permit_i(use_p), .pin_n_o(pin_n), .permit_o(permit));
  sphc_top uut (.clk_sys_i, .rst_i, .hold_request_pin_n_i(pin_n), .hold_permit_i(permit), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .core_out_i(8'ha5),
    .core_oe_i(8'hff), .pad_in_i(pad_in), .pad_out_o(pad_out), .pad_oe_o(pad_oe), .pad_pull_en_o(pull_en),
    .pad_pull_up_o(pull_up), .core_in_o(core_in), .synth_power_down_o(synth_pd), .hold_active_o(hold));
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    @(posedge clk_sys_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic wait_hold(input logic v, input int lim);
    n = 0;
    while (hold !== v && n < lim) begin
      @(posedge clk_sys_i);
      #1 n++;
    end
    chk({31'h0, hold}, {31'h0, v});
    if (hold !== v) summarize();
  endtask
  initial begin
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd_reg(CTRL_OFFSET, CTRL_RESET);
    rd_reg(PULL_EN_OFFSET, PULL_RESET);
    wr_reg(4'h2, 32'hff);
    rd_reg(4'h2, 32'h0);
    wr_reg(PULL_EN_OFFSET, 32'h0f);
    wr_reg(PULL_UP_OFFSET, 32'h05);
    rd_reg(PULL_UP_OFFSET, 32'h05);
    req <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    req <= 1'b0;
    repeat (150) @(posedge clk_sys_i);
    chk({31'h0, hold}, 32'h0);
    req <= 1'b1;
    wait_hold(1'b1, 200);
    chk({31'h0, n >= 100}, 32'h1);
    chk({pad_oe, core_in, 7'h0, synth_pd}, {8'h00, 8'hff, 8'h01});
    chk({pull_en, pull_up}, {8'h0f, 8'h05});
    rd_reg(STATUS_OFFSET, 32'h2);
    req <= 1'b0;
    wait_hold(1'b0, 100);
    chk(pad_oe, 8'hff);
    wr_reg(CTRL_OFFSET, 32'h1);
    rd_reg(CTRL_OFFSET, 32'h1);
    req <= 1'b1;
    repeat (200) @(posedge clk_sys_i);
    chk({31'h0, hold}, 32'h0);
    use_p <= 1'b1;
    wait_hold(1'b1, 150);
    req <= 1'b0;
    wait_hold(1'b0, 100);
    summarize();
  end
endmodule
`default_nettype wire
